/* File: pkg/act_pkg.sv */
// Purpose: Shared constants and types for the acquisition counter timer block.
// Assumes: One 125 MHz core clock and a 32-bit classic Wishbone register port.
// Notes:   Register offsets are byte addresses, each register one aligned word.
package act_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICK_PERIOD_US = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_PERIOD_US;
  localparam int CNT_W = 32;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_AST_PERIOD = 8'h04;
  localparam logic [7:0] REG_SYNC_WIDTH = 8'h08;
  localparam logic [7:0] REG_RESET_WIDTH = 8'h0c;
  localparam logic [7:0] REG_DELAY = 8'h10;
  localparam logic [7:0] REG_EVT_RUNNING = 8'h14;
  localparam logic [7:0] REG_EVT_FINAL = 8'h18;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h20;
  localparam logic [7:0] REG_CAM_OUT = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_7fff;
  localparam logic [31:0] CAMO_RST = 32'h0000_0000;
  localparam logic [31:0] CAMO_MASK = 32'h0000_00ff;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [7:0] IRQ_RST = 8'h00;
  localparam int CAMO_SEL_LSB = 4;

  // ****************************************************************
  // Field types
  // ****************************************************************
  typedef enum logic [1:0] {EVT_LINE, EVT_FRAME, EVT_USEC, EVT_NONE} act_evt_t;
  typedef enum logic [1:0] {GATE_LINE, GATE_FRAME, GATE_TRIG, GATE_ACQ} act_gate_t;

  // Control word, least significant member at bit 0.
  typedef struct packed {
    logic [16:0] rsvd;
    logic acq_active;
    logic mono_from_astable;
    logic trig_from_astable;
    act_gate_t gate;
    act_evt_t evt;
    logic delay_lines;
    logic trig_edge;
    logic [1:0] trig_src;
    logic evt_en;
    logic delay_en;
    logic mono_en;
    logic astable_en;
  } act_ctrl_t;

  // Interrupt events, one status and mask bit each.
  typedef struct packed {
    logic gate_end;
    logic delay_fire;
    logic eol;
    logic sol;
    logic eof;
    logic sof;
    logic fifo_ovf;
    logic acq_done;
  } act_irq_t;

endpackage

/* File: hdl/act_tick_div.sv */
// Purpose: Prescaler that gives a one-cycle microsecond enable pulse.
// Assumes: DIV core clock cycles make one microsecond.
// Notes:   The pulse steps the astable, the monostables, and the delay and event counter in their microsecond modes, so these step together.
`timescale 1ns/100ps
module act_tick_div
#(
  parameter int unsigned DIV = 125
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  output logic tick_out
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  // Wrap the counter and flag the last cycle of each microsecond.
  always_comb
  begin
    nxt_tick = (cnt_ff == LAST);
    nxt_cnt = nxt_tick ? '0 : cnt_ff + 1'b1;
  end

  // State registers.
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_out = tick_ff;

endmodule // act_tick_div

/* File: hdl/act_sync.sv */
// Purpose: Three-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to the core clock.
// Notes:   The output moves only once stages two and three agree, which filters runt pulses.
`timescale 1ns/100ps
module act_sync
#(
  parameter int W = 6
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;
  logic [W-1:0] nxt_out;

  // Per bit, take the new level only when the two later stages match.
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
    end
  end

  // Stage one feeds only stage two.
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      out_ff <= '0;
    end
    else
    begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign sync_out = out_ff;

endmodule // act_sync

/* File: hdl/act_counter_timers.sv */
// Purpose: Four 32-bit counter timers of one acquisition channel behind a Wishbone slave.
// Assumes: Camera valid and trigger pins are asynchronous; acquisition done and FIFO overflow are core-clock pulses.
// Notes:
// Operation
// - The channel holds four independent 32-bit timers: astable, dual monostable, trigger delay, event counter.
// - The astable period is set in microsecond steps from one microsecond up to the full 32-bit range.
// - The astable pulse drives the line rate output and may stand in for the acquisition trigger.
// - Two monostables make the exposure sync pulse and the pixel reset pulse.
// - Both monostables fire on one selected event, each with its own width in microseconds.
// - The trigger delay counts microseconds or lines as software selects.
// - While a delayed trigger is pending, further trigger events are ignored.
// - The event counter counts line starts, frame starts or microsecond ticks.
// - The event counter counts only while the selected gate is true.
// - Software reads both the running count and the count captured at the last gate end.
// - Enabled events raise the interrupt output.
// - The trigger comes from one selected input, taken either by level or by rising edge.
// - Each camera control bit is either a static software level or a monostable pulse (sync on even bits, reset on odd bits).
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/100ps
module act_counter_timers
  import act_pkg::*;
#(
  parameter int NUM_TRIG = 4,
  parameter int CAM_W = 4
)
(
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [ADR_W-1:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic LINE_VALID_IN,
  input wire logic FRAME_VALID_IN,
  input wire logic [NUM_TRIG-1:0] TRIG_IN,
  input wire logic ACQ_DONE_IN,
  input wire logic FIFO_OVF_IN,
  output logic [CAM_W-1:0] CAM_CTRL_OUT,
  output logic ACQ_TRIG_OUT,
  output logic LINE_RATE_OUT,
  output logic IRQ_OUT
);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Step a down-counter by one when enabled, never below zero.
  function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] cnt, input logic step);
    count_down = (step && cnt != '0) ? cnt - 1'b1 : cnt;
  endfunction

  // Merge bus write data into a register under the byte enables.
  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] wdat, input logic [3:0] sel);
    wb_merge = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        wb_merge[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
  endfunction

  // ****************************************************************
  // Timebase and pin synchronisers
  // ****************************************************************
  logic us_tick;
  logic [NUM_TRIG+1:0] pins_s;
  logic lval_s;
  logic fval_s;
  logic [NUM_TRIG-1:0] trig_s;

  act_tick_div #(.DIV(TICK_CYCLES)) u_tick
  (
    .clk_in(CORE_CLK_IN),
    .reset_in(RESET_IN),
    .tick_out(us_tick)
  );

  act_sync #(.W(NUM_TRIG + 2)) u_sync
  (
    .clk_in(CORE_CLK_IN),
    .reset_in(RESET_IN),
    .async_in({TRIG_IN, FRAME_VALID_IN, LINE_VALID_IN}),
    .sync_out(pins_s)
  );

  assign lval_s = pins_s[0];
  assign fval_s = pins_s[1];
  assign trig_s = pins_s[2 +: NUM_TRIG];

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] period_ff, nxt_period;
  logic [31:0] sync_w_ff, nxt_sync_w;
  logic [31:0] reset_w_ff, nxt_reset_w;
  logic [31:0] delay_ff, nxt_delay;
  logic [31:0] camo_ff, nxt_camo;
  act_irq_t irq_st_ff, nxt_irq_st;
  act_irq_t irq_mask_ff, nxt_irq_mask;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic irq_ff, nxt_irq;
  act_ctrl_t ctrl;

  assign ctrl = act_ctrl_t'(ctrl_ff);

  // ****************************************************************
  // Timer state
  // ****************************************************************
  logic lval_d_ff, fval_d_ff, trig_d_ff, gate_d_ff;
  logic [CNT_W-1:0] ast_cnt_ff, nxt_ast_cnt;
  logic ast_fire_ff, nxt_ast_fire;
  logic [CNT_W-1:0] sync_cnt_ff, nxt_sync_cnt;
  logic [CNT_W-1:0] rst_cnt_ff, nxt_rst_cnt;
  logic sync_lvl_ff, nxt_sync_lvl;
  logic rst_lvl_ff, nxt_rst_lvl;
  logic [CNT_W-1:0] dly_cnt_ff, nxt_dly_cnt;
  logic dly_pend_ff, nxt_dly_pend;
  logic acq_fire_ff, nxt_acq_fire;
  logic [CNT_W-1:0] run_cnt_ff, nxt_run_cnt;
  logic [CNT_W-1:0] fin_cnt_ff, nxt_fin_cnt;
  logic [CAM_W-1:0] cam_ff, nxt_cam;

  logic trig_lvl, sol, eol, sof, eof, trig_evt, raw_trig, dly_step, mono_trig;
  logic gate_lvl, gate_rise, gate_fall, evt_step;
  logic [CNT_W-1:0] ast_last;
  act_irq_t events;

  // Edge detection and the selected trigger, from synchronised levels only.
  always_comb
  begin
    trig_lvl = trig_s[ctrl.trig_src];
    sol = lval_s & ~lval_d_ff;
    eol = ~lval_s & lval_d_ff;
    sof = fval_s & ~fval_d_ff;
    eof = ~fval_s & fval_d_ff;
    trig_evt = ctrl.trig_edge ? (trig_lvl & ~trig_d_ff) : trig_lvl;
    raw_trig = ctrl.trig_from_astable ? ast_fire_ff : trig_evt;
    dly_step = ctrl.delay_lines ? sol : us_tick;
    mono_trig = ctrl.mono_from_astable ? ast_fire_ff : acq_fire_ff;
    unique case (ctrl.gate)
      GATE_LINE: gate_lvl = lval_s;
      GATE_FRAME: gate_lvl = fval_s;
      GATE_TRIG: gate_lvl = trig_lvl;
      GATE_ACQ: gate_lvl = ctrl.acq_active;
    endcase
    gate_rise = gate_lvl & ~gate_d_ff;
    gate_fall = ~gate_lvl & gate_d_ff;
    unique case (ctrl.evt)
      EVT_LINE: evt_step = sol;
      EVT_FRAME: evt_step = sof;
      EVT_USEC: evt_step = us_tick;
      EVT_NONE: evt_step = 1'b0;
    endcase
  end

  // Next values of all four timers; each is its own counter and none shares a register.
  always_comb
  begin
    // Astable: a zero period behaves as one microsecond so the output never stalls.
    ast_last = (period_ff == '0) ? '0 : period_ff - 1'b1;
    nxt_ast_cnt = ast_cnt_ff;
    nxt_ast_fire = 1'b0;
    if (!ctrl.astable_en)
    begin
      nxt_ast_cnt = '0;
    end
    else if (us_tick)
    begin
      if (ast_cnt_ff >= ast_last)
      begin
        nxt_ast_cnt = '0;
        nxt_ast_fire = 1'b1;
      end
      else
      begin
        nxt_ast_cnt = ast_cnt_ff + 1'b1;
      end
    end

    // Monostables: a trigger that lands during a pulse does not stretch it.
    nxt_sync_cnt = count_down(sync_cnt_ff, us_tick);
    nxt_rst_cnt = count_down(rst_cnt_ff, us_tick);
    if (!ctrl.mono_en)
    begin
      nxt_sync_cnt = '0;
      nxt_rst_cnt = '0;
    end
    else if (mono_trig)
    begin
      if (sync_cnt_ff == '0)
      begin
        nxt_sync_cnt = sync_w_ff;
      end
      if (rst_cnt_ff == '0)
      begin
        nxt_rst_cnt = reset_w_ff;
      end
    end
    nxt_sync_lvl = (nxt_sync_cnt != '0);
    nxt_rst_lvl = (nxt_rst_cnt != '0);

    // Trigger delay: triggers are dropped while one is pending.
    nxt_dly_cnt = dly_cnt_ff;
    nxt_dly_pend = dly_pend_ff;
    nxt_acq_fire = 1'b0;
    if (!ctrl.delay_en)
    begin
      nxt_dly_pend = 1'b0;
      nxt_dly_cnt = '0;
      nxt_acq_fire = raw_trig;
    end
    else if (dly_pend_ff)
    begin
      if (dly_step)
      begin
        nxt_dly_cnt = count_down(dly_cnt_ff, 1'b1);
        if (dly_cnt_ff <= 32'h0000_0001)
        begin
          nxt_dly_pend = 1'b0;
          nxt_acq_fire = 1'b1;
        end
      end
    end
    else if (raw_trig)
    begin
      if (delay_ff == '0)
      begin
        nxt_acq_fire = 1'b1;
      end
      else
      begin
        nxt_dly_pend = 1'b1;
        nxt_dly_cnt = delay_ff;
      end
    end

    // Event counter: clear at gate start, capture at gate end.
    nxt_run_cnt = run_cnt_ff;
    nxt_fin_cnt = fin_cnt_ff;
    if (!ctrl.evt_en)
    begin
      nxt_run_cnt = '0;
    end
    else
    begin
      if (gate_rise)
      begin
        nxt_run_cnt = '0;
      end
      else if (gate_lvl && evt_step)
      begin
        nxt_run_cnt = run_cnt_ff + 1'b1;
      end
      if (gate_fall)
      begin
        nxt_fin_cnt = run_cnt_ff;
      end
    end

    // Camera control bits: even bits carry the sync pulse, odd bits the reset pulse.
    for (int i = 0; i < CAM_W; i++)
    begin
      if (camo_ff[CAMO_SEL_LSB + i])
      begin
        nxt_cam[i] = i[0] ? nxt_rst_lvl : nxt_sync_lvl;
      end
      else
      begin
        nxt_cam[i] = camo_ff[i];
      end
    end

    events.acq_done = ACQ_DONE_IN;
    events.fifo_ovf = FIFO_OVF_IN;
    events.sof = sof;
    events.eof = eof;
    events.sol = sol;
    events.eol = eol;
    events.delay_fire = nxt_acq_fire;
    events.gate_end = gate_fall & ctrl.evt_en;
  end

  // Timer registers.
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      lval_d_ff <= 1'b0;
      fval_d_ff <= 1'b0;
      trig_d_ff <= 1'b0;
      gate_d_ff <= 1'b0;
      ast_cnt_ff <= '0;
      ast_fire_ff <= 1'b0;
      sync_cnt_ff <= '0;
      rst_cnt_ff <= '0;
      sync_lvl_ff <= 1'b0;
      rst_lvl_ff <= 1'b0;
      dly_cnt_ff <= '0;
      dly_pend_ff <= 1'b0;
      acq_fire_ff <= 1'b0;
      run_cnt_ff <= '0;
      fin_cnt_ff <= '0;
      cam_ff <= '0;
    end
    else
    begin
      lval_d_ff <= lval_s;
      fval_d_ff <= fval_s;
      trig_d_ff <= trig_lvl;
      gate_d_ff <= gate_lvl;
      ast_cnt_ff <= nxt_ast_cnt;
      ast_fire_ff <= nxt_ast_fire;
      sync_cnt_ff <= nxt_sync_cnt;
      rst_cnt_ff <= nxt_rst_cnt;
      sync_lvl_ff <= nxt_sync_lvl;
      rst_lvl_ff <= nxt_rst_lvl;
      dly_cnt_ff <= nxt_dly_cnt;
      dly_pend_ff <= nxt_dly_pend;
      acq_fire_ff <= nxt_acq_fire;
      run_cnt_ff <= nxt_run_cnt;
      fin_cnt_ff <= nxt_fin_cnt;
      cam_ff <= nxt_cam;
    end
  end

  // ****************************************************************
  // Wishbone slave and interrupts
  // ****************************************************************
  logic req, wr_now;
  logic [ADR_W-1:0] adr_w;

  // Ack comes one cycle after the request; writes land on the edge the master sees ack.
  always_comb
  begin
    req = WB_CYC_IN & WB_STB_IN;
    adr_w = {WB_ADR_IN[ADR_W-1:2], 2'b00};
    wr_now = req & WB_WE_IN & ack_ff;
    nxt_ack = req & ~ack_ff;
    nxt_ctrl = ctrl_ff;
    nxt_period = period_ff;
    nxt_sync_w = sync_w_ff;
    nxt_reset_w = reset_w_ff;
    nxt_delay = delay_ff;
    nxt_camo = camo_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_irq_st = irq_st_ff;
    if (wr_now)
    begin
      unique case (adr_w)
        REG_CTRL: nxt_ctrl = wb_merge(ctrl_ff, WB_DAT_IN, WB_SEL_IN) & CTRL_MASK;
        REG_AST_PERIOD: nxt_period = wb_merge(period_ff, WB_DAT_IN, WB_SEL_IN);
        REG_SYNC_WIDTH: nxt_sync_w = wb_merge(sync_w_ff, WB_DAT_IN, WB_SEL_IN);
        REG_RESET_WIDTH: nxt_reset_w = wb_merge(reset_w_ff, WB_DAT_IN, WB_SEL_IN);
        REG_DELAY: nxt_delay = wb_merge(delay_ff, WB_DAT_IN, WB_SEL_IN);
        REG_CAM_OUT: nxt_camo = wb_merge(camo_ff, WB_DAT_IN, WB_SEL_IN) & CAMO_MASK;
        REG_IRQ_MASK: nxt_irq_mask = (WB_SEL_IN[0]) ? act_irq_t'(WB_DAT_IN[7:0]) : irq_mask_ff;
        REG_IRQ_STATUS: nxt_irq_st = (WB_SEL_IN[0]) ? (irq_st_ff & ~act_irq_t'(WB_DAT_IN[7:0])) : irq_st_ff;
        default: nxt_ctrl = ctrl_ff; // Unmapped writes are acknowledged and dropped.
      endcase
    end
    // A new event beats a clear written in the same cycle.
    nxt_irq_st = nxt_irq_st | events;
    nxt_irq = |(nxt_irq_st & nxt_irq_mask);
    nxt_dat = dat_ff;
    if (req && !ack_ff && !WB_WE_IN)
    begin
      unique case (adr_w)
        REG_CTRL: nxt_dat = ctrl_ff;
        REG_AST_PERIOD: nxt_dat = period_ff;
        REG_SYNC_WIDTH: nxt_dat = sync_w_ff;
        REG_RESET_WIDTH: nxt_dat = reset_w_ff;
        REG_DELAY: nxt_dat = delay_ff;
        REG_EVT_RUNNING: nxt_dat = run_cnt_ff;
        REG_EVT_FINAL: nxt_dat = fin_cnt_ff;
        REG_IRQ_STATUS: nxt_dat = {24'h00_0000, irq_st_ff};
        REG_IRQ_MASK: nxt_dat = {24'h00_0000, irq_mask_ff};
        REG_CAM_OUT: nxt_dat = camo_ff;
        REG_STATUS: nxt_dat = {28'h000_0000, gate_d_ff, dly_pend_ff, rst_lvl_ff, sync_lvl_ff};
        default: nxt_dat = 32'h0000_0000;
      endcase
    end
  end

  // Bus and interrupt registers.
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      ctrl_ff <= CTRL_RST;
      period_ff <= WORD_RST;
      sync_w_ff <= WORD_RST;
      reset_w_ff <= WORD_RST;
      delay_ff <= WORD_RST;
      camo_ff <= CAMO_RST;
      irq_st_ff <= IRQ_RST;
      irq_mask_ff <= IRQ_RST;
      ack_ff <= 1'b0;
      dat_ff <= WORD_RST;
      irq_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      period_ff <= nxt_period;
      sync_w_ff <= nxt_sync_w;
      reset_w_ff <= nxt_reset_w;
      delay_ff <= nxt_delay;
      camo_ff <= nxt_camo;
      irq_st_ff <= nxt_irq_st;
      irq_mask_ff <= nxt_irq_mask;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      irq_ff <= nxt_irq;
    end
  end

  assign WB_ACK_OUT = ack_ff;
  assign WB_DAT_OUT = dat_ff;
  assign IRQ_OUT = irq_ff;
  assign CAM_CTRL_OUT = cam_ff;
  assign ACQ_TRIG_OUT = acq_fire_ff;
  assign LINE_RATE_OUT = ast_fire_ff;

endmodule // act_counter_timers

/* File: bench/act_cam_model.sv */
// Purpose: Camera timing and trigger sensor model.
// Assumes: Tasks are entered just after a clock edge.
// Notes:   Pins change right after an edge and stay long enough for the synchroniser.
`timescale 1ns/100ps
module act_cam_model
(
  input wire logic clk_in,
  output logic lval_out,
  output logic fval_out,
  output logic [3:0] trig_out
);
  // ****
  // Pins
  // ****
  // All pins idle low.
  initial {lval_out, fval_out, trig_out} = 6'h00;
  // One frame of n lines; line starts never meet the frame start.
  task automatic frame(input int n);
    fval_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    repeat (n)
    begin
      lval_out <= 1'b1;
      repeat (20) @(posedge clk_in);
      lval_out <= 1'b0;
      repeat (10) @(posedge clk_in);
    end
    fval_out <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask
  // Six cycles, so the runt filter passes it.
  task automatic pulse(input int i);
    trig_out[i] <= 1'b1;
    repeat (6) @(posedge clk_in);
    trig_out[i] <= 1'b0;
  endtask
endmodule // act_cam_model

/* File: bench/act_counter_timers_assertions.sv */
// Purpose: Port assertions for the counter timers.
// Assumes: One clock, reset asynchronous and active high.
// Notes:   Timers are not visible, so their checks are bounds.
`timescale 1ns/100ps
module act_counter_timers_assertions
  import act_pkg::*;
#(
  parameter int NUM_TRIG = 4,
  parameter int CAM_W = 4
)
(
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [ADR_W-1:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  input wire logic LINE_VALID_IN,
  input wire logic FRAME_VALID_IN,
  input wire logic [NUM_TRIG-1:0] TRIG_IN,
  input wire logic ACQ_DONE_IN,
  input wire logic FIFO_OVF_IN,
  input wire logic [CAM_W-1:0] CAM_CTRL_OUT,
  input wire logic ACQ_TRIG_OUT,
  input wire logic LINE_RATE_OUT,
  input wire logic IRQ_OUT
);
  // ****
  // Checks
  // ****
  logic [15:0] gap_ff;
  logic [15:0] nxt_gap;
  // Cycles since the last line pulse; saturates so it never wraps.
  always_comb
  begin
    nxt_gap = gap_ff;
    if (LINE_RATE_OUT)
      nxt_gap = 16'h0000;
    else if (gap_ff != 16'hffff)
      nxt_gap = gap_ff + 16'h0001;
  end
  // Register the gap.
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN)
    if (RESET_IN)
      gap_ff <= 16'hffff;
    else
      gap_ff <= nxt_gap;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);
  property p_ack; WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT; endproperty
  a_ack: assert property (p_ack) else $error("No ack.");
  property p_ack1; WB_ACK_OUT |=> !WB_ACK_OUT; endproperty
  a_ack1: assert property (p_ack1) else $error("Long ack.");
  property p_ack_why; WB_ACK_OUT |-> $past(WB_CYC_IN && WB_STB_IN); endproperty
  a_ack_why: assert property (p_ack_why) else $error("Stray ack.");
  property p_rd_hold; $changed(WB_DAT_OUT) |-> $past(WB_CYC_IN && WB_STB_IN && !WB_WE_IN && !WB_ACK_OUT); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("Read data moved.");
  property p_ctrl_rsvd; WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == REG_CTRL |-> (WB_DAT_OUT & ~CTRL_MASK) == 32'h0;
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("Reserved bits set.");
  property p_rate1; LINE_RATE_OUT |=> !LINE_RATE_OUT; endproperty
  a_rate1: assert property (p_rate1) else $error("Long line pulse.");
  property p_rate_gap; LINE_RATE_OUT |-> gap_ff >= 16'h007c; endproperty
  a_rate_gap: assert property (p_rate_gap) else $error("Line pulses too close.");
  property p_irq_fall; $fell(IRQ_OUT) |-> $past(WB_ACK_OUT && WB_WE_IN); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("Irq fell unasked.");
endmodule // act_counter_timers_assertions
bind act_counter_timers act_counter_timers_assertions #(.NUM_TRIG(NUM_TRIG), .CAM_W(CAM_W)) chk_i (.CORE_CLK_IN,
  .RESET_IN, .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN, .WB_DAT_IN, .WB_DAT_OUT, .WB_ACK_OUT,
  .LINE_VALID_IN, .FRAME_VALID_IN, .TRIG_IN, .ACQ_DONE_IN, .FIFO_OVF_IN, .CAM_CTRL_OUT, .ACQ_TRIG_OUT,
  .LINE_RATE_OUT, .IRQ_OUT);

/* File: bench/act_counter_timers_test.sv */
// Purpose: Self-checking bench for the counter timers.
// Assumes: Classic Wishbone cycles; the camera model drives the pins.
// Notes:   Widths are ranges, as the first tick of a pulse may be partial.
`timescale 1ns/100ps
module act_counter_timers_test
  import act_pkg::*;
;
  logic clk, rst, cyc, stb, we, ack, acq_done, fifo_ovf, lval, fval, acq_trig, line_rate, irq;
  logic [7:0] adr;
  logic [3:0] sel, trig, cam;
  logic [31:0] wdat, rdat, q;
  int errors, checks_done, n0, n1, nl, k, f, g;
  act_counter_timers DUT (.CORE_CLK_IN(clk), .RESET_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .LINE_VALID_IN(lval), .FRAME_VALID_IN(fval), .TRIG_IN(trig), .ACQ_DONE_IN(acq_done), .FIFO_OVF_IN(fifo_ovf),
    .CAM_CTRL_OUT(cam), .ACQ_TRIG_OUT(acq_trig), .LINE_RATE_OUT(line_rate), .IRQ_OUT(irq));
  act_cam_model cam_m (.clk_in(clk), .lval_out(lval), .fval_out(fval), .trig_out(trig));
  // ****
  // Helpers
  // ****
  // One cycle; the request holds until ack is sampled high, read data lands in q.
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    @(posedge clk);
    while (ack !== 1'b1)
    begin
      @(posedge clk);
    end
    q = rdat;
    {cyc, stb} <= 2'h0;
  endtask
  // Counted compare; an unknown never matches.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Counts high cycles of cam[0], cam[1], line_rate and acq_trig; f and g mark the first and last trigger edge.
  task automatic watch(input int span);
    {n0, n1, nl, k, f, g} = '0;
    for (int i = 1; i <= span; i++)
    begin
      @(posedge clk);
      n0 += int'(cam[0] === 1'b1);
      n1 += int'(cam[1] === 1'b1);
      nl += int'(line_rate === 1'b1);
      if (acq_trig === 1'b1)
      begin
        f = (k == 0) ? i : f;
        g = i;
        k++;
      end
    end
  endtask
  // ****
  // Scenarios
  // ****
  // Reset value, full width, reserved bits and an unmapped word.
  task automatic t_regs;
    wb(REG_CTRL, 1'b0, 32'h0);
    chk("ctrl reset", CTRL_RST, q);
    wb(REG_AST_PERIOD, 1'b1, 32'hffff_ffff);
    wb(REG_AST_PERIOD, 1'b0, 32'h0);
    chk("period", 32'hffff_ffff, q);
    wb(REG_CTRL, 1'b1, 32'hffff_ffff);
    wb(REG_CTRL, 1'b0, 32'h0);
    chk("ctrl", CTRL_MASK, q);
    wb(8'h3c, 1'b1, 32'h5);
    wb(8'h3c, 1'b0, 32'h0);
    chk("unmapped", WORD_RST, q);
  endtask
  // A 2 us astable also used as the trigger.
  task automatic t_astable;
    wb(REG_AST_PERIOD, 1'b1, 32'h2);
    wb(REG_CTRL, 1'b1, 32'h1001);
    watch(8 * TICK_CYCLES);
    chk("line pulses", 4, nl);
    chk("trig span", 6 * TICK_CYCLES, g - f);
  endtask
  // Lines within frame gates; the running count restarts each frame.
  task automatic t_evt;
    wb(REG_CTRL, 1'b1, 32'h0408);
    cam_m.frame(3);
    wb(REG_EVT_FINAL, 1'b0, 32'h0);
    chk("final", 3, q);
    fork
      cam_m.frame(5);
      begin
        repeat (60) @(posedge clk);
        wb(REG_EVT_RUNNING, 1'b0, 32'h0);
      end
    join
    chk("running", 2, q);
  endtask
  // One edge trigger fires both monostables; bit 3 is static.
  task automatic t_mono;
    wb(REG_SYNC_WIDTH, 1'b1, 32'h2);
    wb(REG_RESET_WIDTH, 1'b1, 32'h4);
    wb(REG_CAM_OUT, 1'b1, 32'h38);
    wb(REG_CTRL, 1'b1, 32'h0042);
    fork
      cam_m.pulse(0);
      watch(700);
    join
    chk("edge trig", 1, k);
    chk("sync w", 1, n0 > TICK_CYCLES && n0 <= 2 * TICK_CYCLES);
    chk("reset w", 1, n1 > 3 * TICK_CYCLES && n1 <= 4 * TICK_CYCLES);
    chk("cam", 4'h8, cam);
  endtask
  // A second trigger during a pending 3 us delay is dropped.
  task automatic t_delay;
    wb(REG_DELAY, 1'b1, 32'h3);
    wb(REG_CTRL, 1'b1, 32'h0054);
    fork
      watch(700);
      begin
        cam_m.pulse(1);
        repeat (100) @(posedge clk);
        cam_m.pulse(1);
      end
    join
    chk("delayed", 1, k);
    chk("delay", 1, f > 2 * TICK_CYCLES && f <= 4 * TICK_CYCLES);
    wb(REG_CTRL, 1'b1, 32'h00d4);
    fork
      watch(120);
      begin
        cam_m.pulse(1);
        cam_m.frame(3);
      end
    join
    chk("line delay", 1, k == 1 && f > 70 && f <= 90);
  endtask
  // Enabled and masked events, then write-one-to-clear.
  task automatic t_irq;
    wb(REG_CTRL, 1'b1, 32'h0);
    wb(REG_IRQ_STATUS, 1'b1, 32'hff);
    wb(REG_IRQ_MASK, 1'b1, 32'h1);
    {acq_done, fifo_ovf} <= 2'h3;
    @(posedge clk);
    {acq_done, fifo_ovf} <= 2'h0;
    repeat (2) @(posedge clk);
    chk("irq", 1, irq);
    wb(REG_IRQ_STATUS, 1'b0, 32'h0);
    chk("status", 32'h3, q);
    wb(REG_IRQ_STATUS, 1'b1, 32'h1);
    @(posedge clk);
    chk("irq masked", 0, irq);
    wb(REG_IRQ_MASK, 1'b1, 32'h2);
    @(posedge clk);
    chk("irq unmasked", 1, irq);
  endtask
  // Verdict; the single exit of the run.
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // 125 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Reset for 16 cycles, then each scenario.
  initial
  begin
    {rst, cyc, stb, we, acq_done, fifo_ovf, adr, sel, wdat} = {6'h20, 8'h00, 4'hf, 32'h0};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_astable;
    t_evt;
    t_mono;
    t_delay;
    t_irq;
    finish_test;
  end
  // Watchdog far past the few thousand cycles needed.
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test;
  end
endmodule // act_counter_timers_test
